// File: hw/spm_cfg_mem.sv
// small memory holding per-port configuration words, registered read
module spm_cfg_mem (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic [spm_pkg::PORT_IDX_W-1:0] wrIdx,
  input wire logic [7:0] wrData,
  input wire logic [spm_pkg::PORT_IDX_W-1:0] rdIdx,
  output logic [7:0] rdData
);
  import spm_pkg::*;
  logic [7:0] mem_reg [NUM_PORTS];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        mem_reg[i] <= PORT_CFG_RESET;
      end
    end else if (clkEn && wrEn) begin
      mem_reg[wrIdx] <= wrData;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= PORT_CFG_RESET;
    end else if (clkEn) begin
      rdData <= mem_reg[rdIdx];
    end
  end
endmodule // spm_cfg_mem

// File: hw/spm_mode_ctrl.sv
// host-side controller driving shared mode pins and per-port latch pins
// What this block does
// - we drive signal-group high for control chips, low for clock/data chips
// - v.35 is requested as bit2 one, bits 1 and 0 zero
// - mode lines are shared; each port has its own latch as write enable
// - cable-selected: latches tied low, mode pins grounded or floating high
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module spm_mode_ctrl (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  output logic proto_sel_bit0,
  output logic proto_sel_bit1,
  output logic proto_sel_bit2,
  output logic sigGroupSel,
  output logic port_role_sel,
  output logic loopback_req_n,
  output logic enable_combine_n,
  output logic [spm_pkg::NUM_PORTS-1:0] portLatch,
  output logic busy
);
  import spm_pkg::*;

  spm_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [PORT_IDX_W-1:0] idx_reg;
  logic [PORT_IDX_W-1:0] rdIdx;
  logic cable_reg;
  logic [7:0] pins_reg;
  logic [NUM_PORTS-1:0] latch_reg;
  logic [NUM_PORTS-1:0] done_reg;
  logic [7:0] memRd;
  logic memWr;
  logic startReq;
  logic rdPending_reg;
  logic [3:0] rdAddr_reg;
  logic [7:0] pinsNext;

  function automatic logic isPortAddr(input logic [3:0] a);
    return a >= ADDR_PORT0 && a < ADDR_PORT0 + 4'(NUM_PORTS);
  endfunction

  function automatic logic [PORT_IDX_W-1:0] portIdx(input logic [3:0] a);
    logic [3:0] d;
    d = a - ADDR_PORT0;
    return d[PORT_IDX_W-1:0];
  endfunction

  // config writes stored per port; shared pins only change during a sequence or in cable mode
  assign memWr = regWr && isPortAddr(regAddr);
  assign startReq = regWr && regAddr == ADDR_CTRL && regWrData[CTRL_GO];
  assign rdIdx = (state_reg == ST_IDLE && startReq) ? regWrData[CTRL_IDX_LO +: PORT_IDX_W] :
                 (regRd && isPortAddr(regAddr)) ? portIdx(regAddr) : idx_reg;

  spm_cfg_mem cfgMem (
    .mclk(mclk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .wrEn(memWr),
    .wrIdx(portIdx(regAddr)),
    .wrData(regWrData),
    .rdIdx(rdIdx),
    .rdData(memRd)
  );

  // cable mode: latches stay low and all mode lines float high so the cable decides
  always_comb begin
    pinsNext = memRd;
    if (cable_reg) begin
      pinsNext = 8'h7f;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cable_reg <= 1'b0;
    end else if (clkEn && regWr && regAddr == ADDR_CTRL && state_reg == ST_IDLE) begin
      cable_reg <= regWrData[CTRL_CABLE];
    end
  end

  // sequence: present pins, pull one latch low, raise it while the pins hold, return to idle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      idx_reg <= '0;
    end else if (clkEn) begin
      case (state_reg)
        ST_IDLE: begin
          if (startReq && !cable_reg) begin
            idx_reg <= regWrData[CTRL_IDX_LO +: PORT_IDX_W];
            cnt_reg <= SETUP_CYC;
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_reg <= 4'h1) begin
            cnt_reg <= HOLD_CYC;
            state_reg <= ST_LATCH;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_LATCH: begin
          // latch high while lines still hold, then keep them past the edge
          if (cnt_reg <= 4'h1) begin
            cnt_reg <= HOLD_CYC;
            state_reg <= ST_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_HOLD: begin
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // shared pins forced high at the go edge, loaded from the port word on the first setup cycle; latched ports ignore later changes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pins_reg <= 8'h7f;
    end else if (clkEn) begin
      if (cable_reg) begin
        pins_reg <= pinsNext;
      end else if (state_reg == ST_IDLE && startReq) begin
        pins_reg <= 8'h7f;
      end else if (state_reg == ST_SETUP && cnt_reg == SETUP_CYC) begin
        pins_reg <= pinsNext;
      end
    end
  end

  // latches: all high outside a sequence (all low in cable mode) so other ports keep their setup
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      latch_reg <= '1;
    end else if (clkEn) begin
      if (cable_reg) begin
        latch_reg <= '0;
      end else if (state_reg == ST_SETUP) begin
        for (int i = 0; i < NUM_PORTS; i++) begin
          latch_reg[i] <= (PORT_IDX_W'(i) != idx_reg);
        end
      end else begin
        latch_reg <= '1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      done_reg <= '0;
    end else if (clkEn && state_reg == ST_HOLD) begin
      done_reg[idx_reg] <= 1'b1;
    end
  end

  // registered read port
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdPending_reg <= 1'b0;
      rdAddr_reg <= 4'h0;
    end else if (clkEn) begin
      rdPending_reg <= regRd;
      rdAddr_reg <= regAddr;
    end
  end

  always_comb begin
    regRdData = 8'h00;
    if (rdPending_reg) begin
      if (isPortAddr(rdAddr_reg)) begin
        regRdData = memRd;
      end else if (rdAddr_reg == ADDR_CTRL) begin
        regRdData = {2'b00, idx_reg, 2'b00, cable_reg, 1'b0};
      end else if (rdAddr_reg == ADDR_STATUS) begin
        regRdData = {4'h0, done_reg};
      end else if (rdAddr_reg == ADDR_BUSY) begin
        regRdData = {5'h00, pins_reg[2:0] == PROTO_NOCABLE, pins_reg[2:0] == PROTO_V35,
                     state_reg != ST_IDLE};
      end
    end
  end

  assign proto_sel_bit0 = pins_reg[CFG_P0];
  assign proto_sel_bit1 = pins_reg[CFG_P1];
  assign proto_sel_bit2 = pins_reg[CFG_P2];
  assign sigGroupSel = pins_reg[CFG_GRP];
  assign port_role_sel = pins_reg[CFG_ROLE];
  assign loopback_req_n = pins_reg[CFG_LB_N];
  assign enable_combine_n = pins_reg[CFG_EC_N];
  assign portLatch = latch_reg;
  assign busy = state_reg != ST_IDLE;
endmodule // spm_mode_ctrl

// File: hw/spm_pkg.sv
// shared constants and types for the serial port mode controller
package spm_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PORT0 = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_BUSY = 4'h6;
  localparam int NUM_PORTS = 4;
  localparam int PORT_IDX_W = 2;
  localparam logic [7:0] PORT_CFG_RESET = 8'h0f;
  // port config word fields
  localparam int CFG_P0 = 0;
  localparam int CFG_P1 = 1;
  localparam int CFG_P2 = 2;
  localparam int CFG_GRP = 3;
  localparam int CFG_ROLE = 4;
  localparam int CFG_LB_N = 5;
  localparam int CFG_EC_N = 6;
  // ctrl register fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_CABLE = 1;
  localparam int CTRL_IDX_LO = 4;
  // pin timing
  localparam int SETUP_NS = 40;
  localparam int HOLD_NS = 40;
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] PROTO_V35 = 3'h4;
  localparam logic [2:0] PROTO_NOCABLE = 3'h7;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_LATCH, ST_HOLD} spm_state_t;
endpackage

// File: sim/spm_dev_model.sv
// behavioural model of one transceiver port behind the shared mode pins
module spm_dev_model (
  input wire logic latchIn,
  input wire logic [6:0] pinsIn,
  output logic [6:0] held,
  output logic noCable,
  output logic v35Elec,
  output logic drv1En,
  output logic rcv4En,
  output logic termOn,
  output logic gndLoad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic combine;
  // the pins reach the decode only through this buffer
  always_latch begin
    if (!latchIn) begin
      held <= pinsIn;
    end
  end
  assign noCable = held[2:0] == 3'h7;
  assign v35Elec = held[2:0] == 3'h4 && !held[3];
  assign combine = held[3] && !held[6];
  assign drv1En = noCable ? 1'b0 : (combine ? !held[4] : 1'b1);
  assign rcv4En = combine ? held[4] : !noCable;
  assign termOn = v35Elec;
  assign gndLoad = held[2:0] == 3'h6 || (held[2:0] == 3'h4 && held[3]);
endmodule // spm_dev_model

// File: sim/spm_mode_ctrl_props.sv
// port assertions for the mode controller
module spm_mode_ctrl_props (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic proto_sel_bit0,
  input wire logic proto_sel_bit1,
  input wire logic proto_sel_bit2,
  input wire logic sigGroupSel,
  input wire logic port_role_sel,
  input wire logic loopback_req_n,
  input wire logic enable_combine_n,
  input wire logic [spm_pkg::NUM_PORTS-1:0] portLatch,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import spm_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [6:0] pins;
  assign pins = {enable_combine_n, loopback_req_n, port_role_sel, sigGroupSel, proto_sel_bit2, proto_sel_bit1,
    proto_sel_bit0};
  go_starts_a: assert property (clkEn && regWr && regAddr == ADDR_CTRL && regWrData[1:0] == 2'h1 && !busy
    && &portLatch |=> busy) else $error("go did not start a sequence");
  one_latch_a: assert property (busy |-> $onehot0(~portLatch)) else $error("two latches open");
  idle_latch_a: assert property (!busy |-> portLatch == 4'hf || portLatch == 4'h0) else $error("stray latch");
  latch_setup_a: assert property (busy && (portLatch & ~$past(portLatch)) != 4'h0 |-> $stable(pins))
    else $error("pins moved at capture");
  pin_hold_a: assert property ($rose(&portLatch) && busy |=> $stable(pins) [*4]) else $error("hold short");
  cable_pins_a: assert property (portLatch == 4'h0 |-> pins == 7'h7f) else $error("cable pins not high");
  rd_idle_a: assert property (!$past(regRd && clkEn) |-> regRdData == 8'h0) else $error("read data not zero");
  busy_rd_a: assert property ($past(regRd && clkEn && regAddr == ADDR_BUSY) |-> regRdData[2:0] ==
    {pins[2:0] == 3'h7, pins[2:0] == 3'h4, busy}) else $error("status word wrong");
  busy_ends_a: assert property ($rose(busy) |-> ##[8:40] !busy) else $error("sequence too long");
  freeze_a: assert property (!clkEn |=> $stable(pins) && $stable(portLatch)) else $error("moved while frozen");
endmodule // spm_mode_ctrl_props
bind spm_mode_ctrl spm_mode_ctrl_props u_props (.*);

// File: sim/spm_mode_ctrl_tb.sv
// self-checking bench: controller driving four modelled ports
module spm_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spm_pkg::*;
  logic mclk, reset_n, clkEn, regWr, regRd, busy;
  logic [3:0] regAddr, portLatch, noCab;
  logic [7:0] regWrData, regRdData;
  logic [6:0] pins;
  logic [6:0] held [4];
  int error_cnt = 0, n_tests = 0, cyc = 0, seed = 68392, k = 0, done = 0;
  int cfg [4];
  spm_mode_ctrl u_dut (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .proto_sel_bit0(pins[0]), .proto_sel_bit1(pins[1]),
    .proto_sel_bit2(pins[2]), .sigGroupSel(pins[3]), .port_role_sel(pins[4]), .loopback_req_n(pins[5]),
    .enable_combine_n(pins[6]), .portLatch(portLatch), .busy(busy));
  for (genvar i = 0; i < 4; i++) begin : g_dev
    spm_dev_model u_dev (.latchIn(portLatch[i]), .pinsIn(pins), .held(held[i]), .noCable(noCab[i]), .v35Elec(),
      .drv1En(), .rcv4En(), .termOn(), .gndLoad());
  end
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  function automatic int lfsr(int s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(logic [3:0] a, logic [7:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    chk(regRdData, exp);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWrData = 8'h0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    rd(ADDR_PORT0, PORT_CFG_RESET);
    rd(4'hf, 8'h0);
    rd(ADDR_STATUS, 8'h0);
    for (int i = 0; i < 4; i++) cfg[i] = PORT_CFG_RESET;
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      k = i % 4;
      cfg[k] = (seed & 32'h78) | (i % 8);
      wr(ADDR_PORT0 + 4'(k), 8'(cfg[k]));
      rd(ADDR_PORT0 + 4'(k), 8'(cfg[k]));
      if (i == 5) begin
        @(posedge mclk);
        clkEn <= 1'b0;
        repeat (3) @(posedge mclk);
        clkEn <= 1'b1;
      end
      wr(ADDR_CTRL, {2'b0, 2'(k), 4'h1});
      // a second go mid-sequence must be dropped, leaving the next port alone
      if (i == 6) wr(ADDR_CTRL, {2'b0, 2'(k + 1), 4'h1});
      // busy is settled only after the launching edge, so look mid-cycle
      @(negedge mclk);
      while (busy) @(negedge mclk);
      done = done | (1 << k);
      // ports never sequenced hold nothing yet
      for (int j = 0; j < 4; j++) if (done[j]) chk({1'b0, held[j]}, 8'(cfg[j]));
      rd(ADDR_BUSY, {5'b0, i % 8 == 7, i % 8 == 4, 1'b0});
      rd(ADDR_STATUS, 8'(done));
    end
    wr(ADDR_CTRL, 8'h02);
    wr(ADDR_CTRL, 8'h03);
    rd(ADDR_BUSY, 8'h04);
    for (int j = 0; j < 4; j++) chk({noCab[j], held[j]}, 8'hff);
    wr(ADDR_CTRL, 8'h00);
    repeat (3) @(posedge mclk);
    close_out();
  end
endmodule // spm_mode_ctrl_tb
